// ==== verilog/status_groups_pkg.sv ====
// package: shared constants and types for the status register groups
package status_groups_pkg;

  localparam int REG_W = 16;

  // register selectors of the query/command port
  typedef enum logic [2:0] {
    SEL_COND,
    SEL_PTR,
    SEL_NTR,
    SEL_EVENT,
    SEL_ENABLE
  } reg_sel_e;

  // group selectors
  localparam logic GRP_HW2 = 1'b0;
  localparam logic GRP_MEAS = 1'b1;

  // reset values
  localparam logic [15:0] PTR_RESET = 16'hffff;
  localparam logic [15:0] NTR_RESET = 16'h0000;
  localparam logic [15:0] EVENT_RESET = 16'h0000;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;

  // implemented condition bits per group
  localparam logic [15:0] HW2_COND_MASK = 16'h0fff;
  localparam logic [15:0] MEAS_COND_MASK = 16'h0001;

  // hardware-fault group 2 bit positions
  localparam int HW2_REF_LEVEL_BIT = 0;
  localparam int HW2_GEN_AMPL_BIT = 1;
  localparam int HW2_OFFSET_FREQ_BIT = 2;
  localparam int HW2_RF_TUNE_BIT = 3;
  localparam int HW2_RF_RANGE_BIT = 4;
  localparam int HW2_AUDIO_RANGE_BIT = 5;
  localparam int HW2_AM_FM_BIT = 6;
  localparam int HW2_FM_DEV_BIT = 7;
  localparam int HW2_SRC_TWO_VOLT_BIT = 8;
  localparam int HW2_SRC_ONE_NOTCH_BIT = 9;
  localparam int HW2_ACP_WIDE_BIT = 10;
  localparam int HW2_ACP_RBW_BIT = 11;

  // measuring group bit positions
  localparam int MEAS_FER_RUN_BIT = 0;

  // status byte positions
  localparam int STB_HW2_BIT = 1;
  localparam int STB_OPER_BIT = 7;

  // raw fault sources of hardware group 2
  typedef struct packed {
    logic acp_rbw_conflict;
    logic acp_too_wide;
    logic audio_source_one_notch;
    logic audio_source_two_volt;
    logic fm_dev_too_large;
    logic am_fm_both;
    logic audio_range_err;
    logic rf_range_err;
    logic rf_tune_err;
    logic offset_freq_err;
    logic gen_ampl_too_high;
    logic ref_level_err;
  } hw2_faults_s;

  // one query/command request
  typedef struct packed {
    logic valid;
    logic write;
    logic group;
    reg_sel_e sel;
    logic [15:0] data;
  } status_req_s;

endpackage

// ==== verilog/in_sync.sv ====
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module in_sync #(
  parameter int W = 12
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;

  // -------------------------------------------------------------
  // per-bit chain
  // -------------------------------------------------------------
  genvar b;
  generate
    for (b = 0; b < W; b++) begin : g_bit
      always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
          s1_q[b] <= 1'b0;
          s2_q[b] <= 1'b0;
          s3_q[b] <= 1'b0;
          out_q[b] <= 1'b0;
        end else begin
          s1_q[b] <= async_i[b];
          s2_q[b] <= s1_q[b];
          s3_q[b] <= s2_q[b];
          if (s2_q[b] == s3_q[b]) begin
            out_q[b] <= s3_q[b];
          end
        end
      end
    end
  endgenerate

  assign sync_o = out_q;
endmodule

// ==== verilog/status_group.sv ====
// one status register group: filters, event, enable, summary
`timescale 1ns/10ps
module status_group
  import status_groups_pkg::*;
#(
  parameter logic [15:0] COND_MASK = 16'h0fff
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [15:0] cond_i,
  input wire logic wr_ptr_i,
  input wire logic wr_ntr_i,
  input wire logic wr_enable_i,
  input wire logic [15:0] wdata_i,
  input wire logic event_clr_i,
  output logic [15:0] cond_o,
  output logic [15:0] ptr_o,
  output logic [15:0] ntr_o,
  output logic [15:0] event_o,
  output logic [15:0] enable_o,
  output logic summary_o
);
  logic [15:0] cond_q;
  logic [15:0] ptr_q;
  logic [15:0] ntr_q;
  logic [15:0] event_q;
  logic [15:0] enable_q;
  logic [15:0] cond_d;
  logic [15:0] rise;
  logic [15:0] fall;
  logic [15:0] hit;
  logic [15:0] event_d;

  // -------------------------------------------------------------
  // transition detect
  // -------------------------------------------------------------
  assign cond_d = cond_i & COND_MASK;
  assign rise = cond_d & ~cond_q;
  assign fall = ~cond_d & cond_q;
  assign hit = ((rise & ptr_q) | (fall & ntr_q)) & COND_MASK;
  // new hits win over a same-cycle clear
  assign event_d = (event_clr_i ? 16'h0000 : event_q) | hit;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cond_q <= 16'h0000;
      ptr_q <= PTR_RESET;
      ntr_q <= NTR_RESET;
      event_q <= EVENT_RESET;
      enable_q <= ENABLE_RESET;
    end else begin
      cond_q <= cond_d;
      event_q <= event_d;
      if (wr_ptr_i) ptr_q <= wdata_i;
      if (wr_ntr_i) ntr_q <= wdata_i;
      if (wr_enable_i) enable_q <= wdata_i;
    end
  end

  assign cond_o = cond_q;
  assign ptr_o = ptr_q;
  assign ntr_o = ntr_q;
  assign event_o = event_q;
  assign enable_o = enable_q;
  assign summary_o = |(event_q & enable_q);

  AST_EVENT_STICKY: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (event_q != 16'h0000) && !event_clr_i |=> ((event_q & $past(event_q)) == $past(event_q)))
    else $error("event bit lost without clear");
  AST_RISE_LATCH: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (rise & ptr_q) != 16'h0000 |=> (event_q & $past(rise & ptr_q)) == $past(rise & ptr_q))
    else $error("positive transition not latched");
  AST_FALL_LATCH: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (fall & ntr_q) != 16'h0000 |=> (event_q & $past(fall & ntr_q)) == $past(fall & ntr_q))
    else $error("negative transition not latched");
endmodule

// ==== verilog/instrument_status_groups.sv ====
// status reporting for hardware-fault group 2 and the measuring group
// -------------------------------------------------------------
// Functional notes
// - event register clears when queried or on clear-status command.
// - hardware group 2 summary drives status byte bit one.
// - measuring summary reaches bit seven only via enabled operation input.
// - hardware group 2 condition bit 15 reads zero, bits 12-14 unused.
// - bits 11 and 10 flag adjacent-channel-power bandwidth conflicts.
// - bit 9 audio source one notch range, bit 8 source two voltage.
// - bit 7 flags FM deviation too large for generator frequency.
// - bit 6 flags simultaneous AM and FM request.
// - bits 5,4,3 flag audio ranging, RF ranging, RF tuning errors.
// - bit 2 flags generator/analyzer/offset frequency mismatch.
// - bit 1 generator amplitude too high, bit 0 reference level range.
// - measuring condition bit 0 high while frame-error test runs.
// - transition filters accept integer writes and keep them.
// - transition filter queries return stored contents.
// - condition query returns live value without altering it.
// - event query returns accumulated event contents.
// - enable register stores writes and returns them on query.
// -------------------------------------------------------------
`timescale 1ns/10ps
module instrument_status_groups
  import status_groups_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [11:0] hw2_faults_i,
  input wire logic fer_running_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic req_group_i,
  input wire logic [2:0] req_sel_i,
  input wire logic [15:0] req_data_i,
  input wire logic clear_status_i,
  input wire logic oper_meas_enable_i,
  output logic [15:0] rsp_data_o,
  output logic rsp_valid_o,
  output logic stb_hw2_o,
  output logic stb_oper_o,
  output logic meas_summary_o
);
  // -------------------------------------------------------------
  // request decode
  // -------------------------------------------------------------
  status_req_s req;
  hw2_faults_s faults;
  logic [11:0] faults_sync;
  logic [0:0] fer_sync;
  logic [15:0] hw2_cond_in;
  logic [15:0] meas_cond_in;
  logic is_hw2;
  logic is_meas;
  logic rd;
  logic wr;
  logic hw2_clr;
  logic meas_clr;
  logic sel_cond;
  logic sel_ptr;
  logic sel_ntr;
  logic sel_event;
  logic sel_enable;
  logic hw2_wr_ptr;
  logic hw2_wr_ntr;
  logic hw2_wr_enable;
  logic meas_wr_ptr;
  logic meas_wr_ntr;
  logic meas_wr_enable;

  assign req.valid = req_valid_i;
  assign req.write = req_write_i;
  assign req.group = req_group_i;
  assign req.sel = reg_sel_e'(req_sel_i);
  assign req.data = req_data_i;
  assign is_hw2 = req.valid && (req.group == GRP_HW2);
  assign is_meas = req.valid && (req.group == GRP_MEAS);
  assign rd = req.valid && !req.write;
  assign wr = req.valid && req.write;
  assign sel_cond = (req.sel == SEL_COND);
  assign sel_ptr = (req.sel == SEL_PTR);
  assign sel_ntr = (req.sel == SEL_NTR);
  assign sel_event = (req.sel == SEL_EVENT);
  assign sel_enable = (req.sel == SEL_ENABLE);
  assign hw2_clr = clear_status_i || (is_hw2 && rd && sel_event);
  assign meas_clr = clear_status_i || (is_meas && rd && sel_event);
  assign hw2_wr_ptr = is_hw2 && wr && sel_ptr;
  assign hw2_wr_ntr = is_hw2 && wr && sel_ntr;
  assign hw2_wr_enable = is_hw2 && wr && sel_enable;
  assign meas_wr_ptr = is_meas && wr && sel_ptr;
  assign meas_wr_ntr = is_meas && wr && sel_ntr;
  assign meas_wr_enable = is_meas && wr && sel_enable;

  // -------------------------------------------------------------
  // condition inputs
  // -------------------------------------------------------------
  in_sync #(.W(12)) u_hw2_sync (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .async_i(hw2_faults_i),
    .sync_o(faults_sync)
  );
  in_sync #(.W(1)) u_meas_sync (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .async_i(fer_running_i),
    .sync_o(fer_sync)
  );

  assign faults = hw2_faults_s'(faults_sync);
  assign hw2_cond_in[HW2_ACP_RBW_BIT] = faults.acp_rbw_conflict;
  assign hw2_cond_in[HW2_ACP_WIDE_BIT] = faults.acp_too_wide;
  assign hw2_cond_in[HW2_SRC_ONE_NOTCH_BIT] = faults.audio_source_one_notch;
  assign hw2_cond_in[HW2_SRC_TWO_VOLT_BIT] = faults.audio_source_two_volt;
  assign hw2_cond_in[HW2_FM_DEV_BIT] = faults.fm_dev_too_large;
  assign hw2_cond_in[HW2_AM_FM_BIT] = faults.am_fm_both;
  assign hw2_cond_in[HW2_AUDIO_RANGE_BIT] = faults.audio_range_err;
  assign hw2_cond_in[HW2_RF_RANGE_BIT] = faults.rf_range_err;
  assign hw2_cond_in[HW2_RF_TUNE_BIT] = faults.rf_tune_err;
  assign hw2_cond_in[HW2_OFFSET_FREQ_BIT] = faults.offset_freq_err;
  assign hw2_cond_in[HW2_GEN_AMPL_BIT] = faults.gen_ampl_too_high;
  assign hw2_cond_in[HW2_REF_LEVEL_BIT] = faults.ref_level_err;
  assign hw2_cond_in[15:12] = 4'h0;
  assign meas_cond_in = {15'h0000, fer_sync[0]};

  // -------------------------------------------------------------
  // groups
  // -------------------------------------------------------------
  logic [15:0] hw2_cond, hw2_ptr, hw2_ntr, hw2_event, hw2_enable;
  logic [15:0] meas_cond, meas_ptr, meas_ntr, meas_event, meas_enable;
  logic hw2_sum;
  logic meas_sum;

  status_group #(.COND_MASK(HW2_COND_MASK)) u_hw2 (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .cond_i(hw2_cond_in),
    .wr_ptr_i(hw2_wr_ptr),
    .wr_ntr_i(hw2_wr_ntr),
    .wr_enable_i(hw2_wr_enable),
    .wdata_i(req.data),
    .event_clr_i(hw2_clr),
    .cond_o(hw2_cond),
    .ptr_o(hw2_ptr),
    .ntr_o(hw2_ntr),
    .event_o(hw2_event),
    .enable_o(hw2_enable),
    .summary_o(hw2_sum)
  );
  status_group #(.COND_MASK(MEAS_COND_MASK)) u_meas (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .cond_i(meas_cond_in),
    .wr_ptr_i(meas_wr_ptr),
    .wr_ntr_i(meas_wr_ntr),
    .wr_enable_i(meas_wr_enable),
    .wdata_i(req.data),
    .event_clr_i(meas_clr),
    .cond_o(meas_cond),
    .ptr_o(meas_ptr),
    .ntr_o(meas_ntr),
    .event_o(meas_event),
    .enable_o(meas_enable),
    .summary_o(meas_sum)
  );

  // -------------------------------------------------------------
  // query answer mux
  // -------------------------------------------------------------
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    unique case (req.sel)
      SEL_COND: rd_mux = req.group ? meas_cond : hw2_cond;
      SEL_PTR: rd_mux = req.group ? meas_ptr : hw2_ptr;
      SEL_NTR: rd_mux = req.group ? meas_ntr : hw2_ntr;
      SEL_EVENT: rd_mux = req.group ? meas_event : hw2_event;
      SEL_ENABLE: rd_mux = req.group ? meas_enable : hw2_enable;
      default: rd_mux = 16'h0000;
    endcase
  end

  // -------------------------------------------------------------
  // output registers
  // -------------------------------------------------------------
  logic [15:0] rsp_data_q;
  logic rsp_valid_q;
  logic stb_hw2_q;
  logic stb_oper_q;
  logic meas_sum_q;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rsp_data_q <= 16'h0000;
      rsp_valid_q <= 1'b0;
      stb_hw2_q <= 1'b0;
      stb_oper_q <= 1'b0;
      meas_sum_q <= 1'b0;
    end else begin
      rsp_valid_q <= rd;
      if (rd) rsp_data_q <= rd_mux;
      stb_hw2_q <= hw2_sum;
      meas_sum_q <= meas_sum;
      stb_oper_q <= meas_sum && oper_meas_enable_i;
    end
  end

  assign rsp_data_o = rsp_data_q;
  assign rsp_valid_o = rsp_valid_q;
  assign stb_hw2_o = stb_hw2_q;
  assign stb_oper_o = stb_oper_q;
  assign meas_summary_o = meas_sum_q;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  AST_EVENT_READ_CLEARS: assert property (@(posedge core_clk_i) disable iff (reset_i)
    rd && req.sel == SEL_EVENT && req.group == GRP_HW2 && hw2_cond_in == hw2_cond
    |=> hw2_event == 16'h0000)
    else $error("event register not cleared by query");
  AST_CLS_CLEARS: assert property (@(posedge core_clk_i) disable iff (reset_i)
    clear_status_i && meas_cond_in == meas_cond |=> meas_event == 16'h0000)
    else $error("clear status did not clear event");
  AST_STB_HW2: assert property (@(posedge core_clk_i) disable iff (reset_i)
    ##1 stb_hw2_o == $past(|(hw2_event & hw2_enable)))
    else $error("status bit one mismatch");
  AST_STB_OPER: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !oper_meas_enable_i |=> !stb_oper_o)
    else $error("measuring summary passed without enable");
  AST_HW2_TOP_ZERO: assert property (@(posedge core_clk_i) disable iff (reset_i)
    hw2_cond[15:12] == 4'h0)
    else $error("unused hardware condition bits set");
  AST_MEAS_UNUSED: assert property (@(posedge core_clk_i) disable iff (reset_i)
    meas_cond[15:1] == 15'h0000)
    else $error("unused measuring condition bits set");
  AST_COND_READ: assert property (@(posedge core_clk_i) disable iff (reset_i)
    rd && req.sel == SEL_COND && req.group == GRP_HW2 |=> rsp_valid_o
    && rsp_data_o == $past(hw2_cond) && hw2_cond == $past(hw2_cond_in & HW2_COND_MASK))
    else $error("condition query wrong");
  AST_ENABLE_RW: assert property (@(posedge core_clk_i) disable iff (reset_i)
    wr && req.sel == SEL_ENABLE && req.group == GRP_MEAS |=> meas_enable == $past(req_data_i))
    else $error("enable write not stored");
  AST_PTR_RW: assert property (@(posedge core_clk_i) disable iff (reset_i)
    wr && req.sel == SEL_PTR && req.group == GRP_HW2 |=> hw2_ptr == $past(req_data_i))
    else $error("positive filter write not stored");
  AST_EVENT_READ: assert property (@(posedge core_clk_i) disable iff (reset_i)
    rd && req.sel == SEL_EVENT && req.group == GRP_MEAS |=> rsp_data_o == $past(meas_event))
    else $error("event query wrong");
  AST_SUMMARY: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (meas_event & meas_enable) != 16'h0000 |=> meas_summary_o)
    else $error("summary not raised");

  // -------------------------------------------------------------
  // access and summary checks
  // -------------------------------------------------------------
  AST_MEAS_READ_CLEARS: assert property (@(posedge core_clk_i) disable iff (reset_i)
    is_meas && rd && sel_event && meas_cond_in == meas_cond |=> meas_event == 16'h0000)
    else $error("measuring event not cleared by query");
  AST_HW2_CLS_CLEARS: assert property (@(posedge core_clk_i) disable iff (reset_i)
    clear_status_i && hw2_cond_in == hw2_cond |=> hw2_event == 16'h0000)
    else $error("clear status did not clear hardware event");
  AST_SET_WINS: assert property (@(posedge core_clk_i) disable iff (reset_i)
    hw2_clr && (hw2_cond_in & ~hw2_cond & hw2_ptr) != 16'h0000 |=> hw2_event != 16'h0000)
    else $error("new event lost to same-cycle clear");
  AST_HW2_NTR_RW: assert property (@(posedge core_clk_i) disable iff (reset_i)
    hw2_wr_ntr |=> hw2_ntr == $past(req_data_i))
    else $error("negative filter write not stored");
  AST_MEAS_PTR_RW: assert property (@(posedge core_clk_i) disable iff (reset_i)
    meas_wr_ptr |=> meas_ptr == $past(req_data_i))
    else $error("measuring positive filter write not stored");
  AST_MEAS_NTR_RW: assert property (@(posedge core_clk_i) disable iff (reset_i)
    meas_wr_ntr |=> meas_ntr == $past(req_data_i))
    else $error("measuring negative filter write not stored");
  AST_HW2_ENABLE_RW: assert property (@(posedge core_clk_i) disable iff (reset_i)
    hw2_wr_enable |=> hw2_enable == $past(req_data_i))
    else $error("hardware enable write not stored");
  AST_HW2_PTR_READ: assert property (@(posedge core_clk_i) disable iff (reset_i)
    is_hw2 && rd && sel_ptr |=> rsp_data_o == $past(hw2_ptr))
    else $error("positive filter query wrong");
  AST_MEAS_NTR_READ: assert property (@(posedge core_clk_i) disable iff (reset_i)
    is_meas && rd && sel_ntr |=> rsp_data_o == $past(meas_ntr))
    else $error("negative filter query wrong");
  AST_HW2_ENABLE_READ: assert property (@(posedge core_clk_i) disable iff (reset_i)
    is_hw2 && rd && sel_enable |=> rsp_data_o == $past(hw2_enable))
    else $error("enable query wrong");
  AST_HW2_EVENT_READ: assert property (@(posedge core_clk_i) disable iff (reset_i)
    is_hw2 && rd && sel_event |=> rsp_data_o == $past(hw2_event))
    else $error("hardware event query wrong");
  AST_MEAS_COND_KEPT: assert property (@(posedge core_clk_i) disable iff (reset_i)
    is_meas && rd && sel_cond |=> rsp_data_o == $past(meas_cond)
    && meas_cond == $past(meas_cond_in))
    else $error("measuring condition query wrong");
  AST_BAD_SEL_ZERO: assert property (@(posedge core_clk_i) disable iff (reset_i)
    rd && req_sel_i > 3'h4 |=> rsp_data_o == 16'h0000)
    else $error("unknown selector query not zero");
  AST_RSP_PULSE: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !rd |=> !rsp_valid_o)
    else $error("answer strobe without query");
  AST_WRITE_NO_ANSWER: assert property (@(posedge core_clk_i) disable iff (reset_i)
    wr |=> !rsp_valid_o && rsp_data_o == $past(rsp_data_o))
    else $error("write produced an answer");
  AST_HW2_SUMMARY: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (hw2_event & hw2_enable) != 16'h0000 |=> stb_hw2_o)
    else $error("status bit one not raised");
  AST_STB_OPER_PASS: assert property (@(posedge core_clk_i) disable iff (reset_i)
    meas_sum && oper_meas_enable_i |=> stb_oper_o)
    else $error("enabled measuring summary not passed");
  AST_FER_BIT: assert property (@(posedge core_clk_i) disable iff (reset_i)
    ##1 meas_cond[MEAS_FER_RUN_BIT] == $past(fer_sync[0]))
    else $error("frame-error running bit wrong");
  AST_SUMMARY_LOW: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (meas_event & meas_enable) == 16'h0000 |=> !meas_summary_o)
    else $error("summary high without enabled event");
endmodule

// ==== dv/status_host.sv ====
// remote controller model issuing status queries and commands
`timescale 1ns/10ps
module status_host
  import status_groups_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic [15:0] rsp_data_i,
  input wire logic rsp_valid_i,
  output logic req_valid_o,
  output logic req_write_o,
  output logic req_group_o,
  output logic [2:0] req_sel_o,
  output logic [15:0] req_data_o,
  output logic clear_status_o,
  output logic oper_meas_enable_o
);
  initial begin
    req_valid_o = 1'b0;
    req_write_o = 1'b0;
    req_group_o = 1'b0;
    req_sel_o = 3'h0;
    req_data_o = 16'h0000;
    clear_status_o = 1'b0;
    oper_meas_enable_o = 1'b0;
  end

  // -------------------------------------------------------------
  // request cycle: set at falling edge, held over the taking edge
  // -------------------------------------------------------------
  task automatic send(input logic wr, input logic grp, input logic [2:0] sel,
                      input logic [15:0] d);
    @(negedge core_clk_i);
    req_valid_o = 1'b1;
    req_write_o = wr;
    req_group_o = grp;
    req_sel_o = sel;
    req_data_o = d;
    @(posedge core_clk_i);
    @(negedge core_clk_i);
    req_valid_o = 1'b0;
    req_data_o = ~d;
  endtask

  // query with bounded wait for the answer
  task automatic query(input logic grp, input logic [2:0] sel, output logic [15:0] d,
                       output bit ok);
    ok = 1'b0;
    d = 16'h0000;
    send(1'b0, grp, sel, 16'h0000);
    for (int i = 0; i < 3 && !ok; i++) begin
      if (rsp_valid_i === 1'b1) begin
        ok = 1'b1;
        d = rsp_data_i;
      end else begin
        @(negedge core_clk_i);
      end
    end
  endtask

  // clear-status command pulse
  task automatic clear_status();
    @(negedge core_clk_i);
    clear_status_o = 1'b1;
    @(negedge core_clk_i);
    clear_status_o = 1'b0;
  endtask

  // operation group enable for the measuring summary
  task automatic set_oper(input logic en);
    @(negedge core_clk_i);
    oper_meas_enable_o = en;
  endtask
endmodule

// ==== dv/testbench.sv ====
// self-checking testbench for the status register groups
`timescale 1ns/10ps
module testbench
  import status_groups_pkg::*;
;
  logic core_clk_i = 1'b0;
  logic reset_i;
  logic [11:0] hw2_faults;
  logic fer_running;
  logic req_valid, req_write, req_group, clear_status, oper_en;
  logic [2:0] req_sel;
  logic [15:0] req_data, rsp_data;
  logic rsp_valid, stb_hw2, stb_oper, meas_summary;
  int bad_count = 0;
  int tests_run = 0;

  always #4 core_clk_i = ~core_clk_i;

  instrument_status_groups instrument_status_groups_inst (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .hw2_faults_i(hw2_faults),
    .fer_running_i(fer_running), .req_valid_i(req_valid), .req_write_i(req_write),
    .req_group_i(req_group), .req_sel_i(req_sel), .req_data_i(req_data),
    .clear_status_i(clear_status), .oper_meas_enable_i(oper_en),
    .rsp_data_o(rsp_data), .rsp_valid_o(rsp_valid), .stb_hw2_o(stb_hw2),
    .stb_oper_o(stb_oper), .meas_summary_o(meas_summary)
  );

  status_host status_host_inst (
    .core_clk_i(core_clk_i), .rsp_data_i(rsp_data), .rsp_valid_i(rsp_valid),
    .req_valid_o(req_valid), .req_write_o(req_write), .req_group_o(req_group),
    .req_sel_o(req_sel), .req_data_o(req_data), .clear_status_o(clear_status),
    .oper_meas_enable_o(oper_en)
  );

  // -------------------------------------------------------------
  // report and compare tasks
  // -------------------------------------------------------------
  task automatic end_of_test();
    $display("mismatches %0d, comparisons %0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t word got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t flag got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic rd(input logic grp, input logic [2:0] sel, input logic [15:0] exp);
    logic [15:0] d;
    bit ok;
    status_host_inst.query(grp, sel, d, ok);
    if (!ok) begin
      bad_count++;
      $display("[FAIL] %0t no answer to query", $time);
      end_of_test();
    end else begin
      chk16(d, exp);
    end
  endtask

  task automatic wr(input logic grp, input logic [2:0] sel, input logic [15:0] d);
    status_host_inst.send(1'b1, grp, sel, d);
  endtask

  // fault levels, then time for sync, condition, event and summary
  task automatic set_in(input logic [11:0] f, input logic fer);
    @(negedge core_clk_i);
    hw2_faults = f;
    fer_running = fer;
    repeat (10) @(negedge core_clk_i);
  endtask

  task automatic settle();
    repeat (3) @(negedge core_clk_i);
  endtask

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    hw2_faults = 12'h000;
    fer_running = 1'b0;
    reset_i = 1'b1;
    repeat (4) @(posedge core_clk_i);
    @(negedge core_clk_i);
    reset_i = 1'b0;
    for (int g = 0; g < 2; g++) begin
      rd(g[0], SEL_COND, 16'h0000);
      rd(g[0], SEL_PTR, PTR_RESET);
      rd(g[0], SEL_NTR, NTR_RESET);
      rd(g[0], SEL_EVENT, EVENT_RESET);
      rd(g[0], SEL_ENABLE, ENABLE_RESET);
      wr(g[0], SEL_PTR, 16'h1234 + 16'(g));
      wr(g[0], SEL_NTR, 16'h8001);
      wr(g[0], SEL_ENABLE, 16'h00f0);
      wr(g[0], SEL_COND, 16'hffff);
      wr(g[0], 3'h7, 16'hffff);
      rd(g[0], SEL_PTR, 16'h1234 + 16'(g));
      rd(g[0], SEL_NTR, 16'h8001);
      rd(g[0], SEL_ENABLE, 16'h00f0);
      rd(g[0], SEL_COND, 16'h0000);
      rd(g[0], 3'h7, 16'h0000);
      wr(g[0], SEL_PTR, 16'hffff);
      wr(g[0], SEL_NTR, 16'h0000);
      wr(g[0], SEL_ENABLE, 16'h0000);
    end
    for (int i = 0; i < 12; i++) begin
      set_in(12'(1 << i), 1'b0);
      rd(GRP_HW2, SEL_COND, 16'(1 << i));
    end
    set_in(12'hfff, 1'b0);
    rd(GRP_HW2, SEL_COND, 16'h0fff);
    rd(GRP_HW2, SEL_COND, 16'h0fff);
    rd(GRP_HW2, SEL_EVENT, 16'h0fff);
    rd(GRP_HW2, SEL_EVENT, 16'h0000);
    wr(GRP_HW2, SEL_PTR, 16'h0001);
    wr(GRP_HW2, SEL_NTR, 16'h0002);
    set_in(12'h000, 1'b0);
    set_in(12'h001, 1'b0);
    set_in(12'h003, 1'b0);
    rd(GRP_HW2, SEL_EVENT, 16'h0003);
    wr(GRP_HW2, SEL_ENABLE, 16'h0002);
    set_in(12'h001, 1'b0);
    chk1(stb_hw2, 1'b1);
    rd(GRP_HW2, SEL_EVENT, 16'h0002);
    settle();
    chk1(stb_hw2, 1'b0);
    set_in(12'h003, 1'b0);
    set_in(12'h001, 1'b0);
    chk1(stb_hw2, 1'b1);
    status_host_inst.clear_status();
    settle();
    chk1(stb_hw2, 1'b0);
    rd(GRP_HW2, SEL_EVENT, 16'h0000);
    wr(GRP_MEAS, SEL_ENABLE, 16'h0001);
    set_in(12'h001, 1'b1);
    rd(GRP_MEAS, SEL_COND, 16'h0001);
    chk1(meas_summary, 1'b1);
    chk1(stb_oper, 1'b0);
    status_host_inst.set_oper(1'b1);
    settle();
    chk1(stb_oper, 1'b1);
    status_host_inst.set_oper(1'b0);
    settle();
    chk1(stb_oper, 1'b0);
    rd(GRP_MEAS, SEL_EVENT, 16'h0001);
    settle();
    chk1(meas_summary, 1'b0);
    set_in(12'h001, 1'b0);
    rd(GRP_MEAS, SEL_EVENT, 16'h0000);
    end_of_test();
  end
endmodule
